// file: src/otr_pkg.sv
// package: register map, reset values and field layout of the trim bank
package otr_pkg;
  // printed offsets are not all multiples of four: each is an index
  localparam logic [11:0] OTR_IDX_C1_INA  = 12'h08e;
  localparam logic [11:0] OTR_IDX_C1_INB  = 12'h090;
  localparam logic [11:0] OTR_IDX_C2_INA  = 12'h092;
  localparam logic [11:0] OTR_IDX_C2_INB  = 12'h094;
  localparam logic [11:0] OTR_IDX_CAL_STS = 12'h099;
  localparam int          OTR_IDX_SHIFT   = 2;

  localparam int          OTR_NUM_TRIM    = 4;
  localparam int          OTR_TRIM_W      = 12;
  localparam int          OTR_REG_W       = 16;
  localparam int          OTR_RSV_LSB     = 12;
  localparam logic [3:0]  OTR_RSV_RESET   = 4'h0;

  // factory trim levels loaded at reset
  localparam logic [11:0] OTR_FACTORY_C1_INA = 12'h800;
  localparam logic [11:0] OTR_FACTORY_C1_INB = 12'h800;
  localparam logic [11:0] OTR_FACTORY_C2_INA = 12'h800;
  localparam logic [11:0] OTR_FACTORY_C2_INB = 12'h800;

  // calibration status register bit positions
  localparam int OTR_STS_FG_RUN   = 0;
  localparam int OTR_STS_BG_EN    = 1;
  localparam int OTR_STS_BGOS_EN  = 2;
  localparam int OTR_STS_FGOS_EN  = 3;
  localparam int OTR_STS_FOREGROUND_CAL_DONE_FLAG  = 4;
  localparam int OTR_STS_STOPPED  = 5;
  localparam int OTR_STS_WR_OK    = 6;
  localparam int OTR_STS_RD_OK    = 7;

  localparam logic [1:0]  OTR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  OTR_RESP_SLVERR = 2'h2;

  // decoded register selector
  typedef enum logic [2:0] {
    OTR_SEL_C1_INA,
    OTR_SEL_C1_INB,
    OTR_SEL_C2_INA,
    OTR_SEL_C2_INB,
    OTR_SEL_STS,
    OTR_SEL_NONE
  } otr_sel_e;
endpackage : otr_pkg

// file: src/otr_trim_bank.sv
// module: offset trim register bank with axi4-lite slave and trim datapath
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps

// register map, byte address = index * 4, one 16-bit word per slot:
//   index 0x08e  core1 trim, input A
//   index 0x090  core1 trim, input B
//   index 0x092  core2 trim, input A
//   index 0x094  core2 trim, input B
//   index 0x099  calibration status, read only
// trim word: bits 15:12 spare, read/write; bits 11:0 unsigned trim
// writes outside the allowed window are dropped with slverr; reads
// outside it still return data but flag slverr, so software can
// tell a possibly half-updated trim from a settled one
module otr_trim_bank
  import otr_pkg::*;
(
  // clock and reset
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  // axi4-lite write address
  input  wire  logic [11:0] s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  // axi4-lite write data
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  // axi4-lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // axi4-lite read address
  input  wire  logic [11:0] s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  // axi4-lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // calibration state from the calibration engine
  input  wire  logic        foreground_cal_running,
  input  wire  logic        background_cal_enable,
  input  wire  logic        background_offset_cal_enable,
  input  wire  logic        foreground_offset_cal_enable,
  input  wire  logic        foreground_cal_done_flag,
  input  wire  logic        calibration_stopped_flag,
  // sample datapath
  input  wire  logic        core1_on_input_b,
  input  wire  logic        core2_on_input_b,
  input  wire  logic [11:0] core1_sample,
  input  wire  logic [11:0] core2_sample,
  output logic [12:0]       core1_corrected,
  output logic [12:0]       core2_corrected
);

  function automatic otr_sel_e otr_decode(input logic [11:0] addr);
    otr_sel_e sel;
    sel = OTR_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr >> OTR_IDX_SHIFT)
        OTR_IDX_C1_INA:  sel = OTR_SEL_C1_INA;
        OTR_IDX_C1_INB:  sel = OTR_SEL_C1_INB;
        OTR_IDX_C2_INA:  sel = OTR_SEL_C2_INA;
        OTR_IDX_C2_INB:  sel = OTR_SEL_C2_INB;
        OTR_IDX_CAL_STS: sel = OTR_SEL_STS;
        default:         sel = OTR_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : otr_decode

  // true for the four trim words, false for status and holes
  function automatic logic otr_is_trim(input otr_sel_e sel);
    logic hit;
    hit = 1'b0;
    case (sel)
      OTR_SEL_C1_INA, OTR_SEL_C1_INB,
      OTR_SEL_C2_INA, OTR_SEL_C2_INB: hit = 1'b1;
      default:                        hit = 1'b0;
    endcase
    return hit;
  endfunction : otr_is_trim

  // trim field for the input a core is sampling; stored unsigned
  function automatic logic [OTR_TRIM_W-1:0] otr_pick_trim(
    input logic                 on_b,
    input logic [OTR_REG_W-1:0] trim_a,
    input logic [OTR_REG_W-1:0] trim_b
  );
    logic [OTR_TRIM_W-1:0] pick;
    pick = on_b ? trim_b[OTR_TRIM_W-1:0] : trim_a[OTR_TRIM_W-1:0];
    return pick;
  endfunction : otr_pick_trim

  localparam logic [11:0] FACTORY [OTR_NUM_TRIM] = '{
    OTR_FACTORY_C1_INA, OTR_FACTORY_C1_INB,
    OTR_FACTORY_C2_INA, OTR_FACTORY_C2_INB
  };

  logic [OTR_REG_W-1:0] trim_r [OTR_NUM_TRIM];
  logic [11:0]          awaddr_r;
  logic                 aw_held_r;
  logic [15:0]          wdata_r;
  logic [1:0]           wstrb_r;
  logic                 w_held_r;
  logic                 wr_ok;
  logic                 rd_ok;
  logic                 do_write;
  otr_sel_e             wr_sel;
  otr_sel_e             rd_sel;
  logic [7:0]           cal_status;
  logic [OTR_REG_W-1:0] wr_merged;
  logic                 bg_offset_active;
  logic                 fg_offset_pending;
  logic                 wr_reject;
  logic                 rd_unsettled;

  // background offset loop owns the trims while both enables are set
  assign bg_offset_active = background_cal_enable
                         && background_offset_cal_enable;
  // foreground offset result not yet settled
  assign fg_offset_pending = foreground_offset_cal_enable
                          && !background_offset_cal_enable
                          && !foreground_cal_done_flag;

  // the calibration engine owns the trims in these windows; guarding
  // here keeps a stray write from corrupting a run in progress
  assign wr_ok = !foreground_cal_running
               && !bg_offset_active;
  // reads outside these windows may catch a half-updated trim
  assign rd_ok = !fg_offset_pending
               && !(bg_offset_active
                    && !calibration_stopped_flag);

  // status word: one flag per bit, positions from the package
  always_comb begin
    cal_status                  = 8'h00;
    cal_status[OTR_STS_FG_RUN]  = foreground_cal_running;
    cal_status[OTR_STS_BG_EN]   = background_cal_enable;
    cal_status[OTR_STS_BGOS_EN] = background_offset_cal_enable;
    cal_status[OTR_STS_FGOS_EN] = foreground_offset_cal_enable;
    cal_status[OTR_STS_FOREGROUND_CAL_DONE_FLAG] = foreground_cal_done_flag;
    cal_status[OTR_STS_STOPPED] = calibration_stopped_flag;
    cal_status[OTR_STS_WR_OK]   = wr_ok;
    cal_status[OTR_STS_RD_OK]   = rd_ok;
  end

  assign wr_sel   = otr_decode(awaddr_r);
  assign rd_sel   = otr_decode(s_axi_araddr);
  // both halves held and no answer pending: one write in flight
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // refused: hole, status word, or a trim write outside its window
  assign wr_reject = !otr_is_trim(wr_sel) || !wr_ok;

  // trim read outside its window: data returned, answer flagged
  assign rd_unsettled = otr_is_trim(rd_sel) && !rd_ok;

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      awaddr_r      <= 12'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r     <= 1'b1;
      awaddr_r      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held_r     <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data capture, only the low two lanes carry register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r     <= 1'b0;
      wdata_r      <= 16'h0000;
      wstrb_r      <= 2'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r     <= 1'b1;
      wdata_r      <= s_axi_wdata[15:0];
      wstrb_r      <= s_axi_wstrb[1:0];
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held_r     <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= OTR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (wr_reject) begin
        s_axi_bresp <= OTR_RESP_SLVERR;
      end else begin
        s_axi_bresp <= OTR_RESP_OKAY;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte-lane merge over the addressed word; spare bits ride lane 1
  always_comb begin
    wr_merged = 16'h0000;
    case (wr_sel)
      OTR_SEL_C1_INA: wr_merged = trim_r[0];
      OTR_SEL_C1_INB: wr_merged = trim_r[1];
      OTR_SEL_C2_INA: wr_merged = trim_r[2];
      OTR_SEL_C2_INB: wr_merged = trim_r[3];
      default:        wr_merged = 16'h0000;
    endcase
    if (wstrb_r[0]) begin
      wr_merged[7:0] = wdata_r[7:0];
    end
    if (wstrb_r[1]) begin
      wr_merged[15:8] = wdata_r[15:8];
    end
  end

  // trim storage, one word per core and input
  for (genvar g = 0; g < OTR_NUM_TRIM; g++) begin : g_trim
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        trim_r[g] <= {OTR_RSV_RESET, FACTORY[g]};
      end else if (do_write && wr_ok
                   && wr_sel == otr_sel_e'(g)) begin
        trim_r[g] <= wr_merged;
      end
    end
  end

  // read channel, data registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= OTR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= OTR_RESP_OKAY;
      case (rd_sel)
        OTR_SEL_C1_INA: s_axi_rdata <= {16'h0000, trim_r[0]};
        OTR_SEL_C1_INB: s_axi_rdata <= {16'h0000, trim_r[1]};
        OTR_SEL_C2_INA: s_axi_rdata <= {16'h0000, trim_r[2]};
        OTR_SEL_C2_INB: s_axi_rdata <= {16'h0000, trim_r[3]};
        OTR_SEL_STS:    s_axi_rdata <= {24'h00_0000, cal_status};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= OTR_RESP_SLVERR;
        end
      endcase
      // data still returned, but flagged as possibly unsettled
      if (rd_unsettled) begin
        s_axi_rresp <= OTR_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // offset correction: trim added as an unsigned value, no wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core1_corrected <= 13'h0000;
      core2_corrected <= 13'h0000;
    end else begin
      core1_corrected <= {1'b0, core1_sample}
        + {1'b0, otr_pick_trim(core1_on_input_b,
                               trim_r[0], trim_r[1])};
      core2_corrected <= {1'b0, core2_sample}
        + {1'b0, otr_pick_trim(core2_on_input_b,
                               trim_r[2], trim_r[3])};
    end
  end

endmodule : otr_trim_bank

// file: dv/otr_trim_bank_assertions.sv
// checker: handshake timing and calibration gating of the trim bank
`timescale 1ns/10ps
module otr_trim_bank_chk
  import otr_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // axi4-lite
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // calibration state
  input wire logic        foreground_cal_running,
  input wire logic        background_cal_enable,
  input wire logic        background_offset_cal_enable,
  input wire logic        foreground_offset_cal_enable,
  input wire logic        foreground_cal_done_flag,
  input wire logic        calibration_stopped_flag
);
  wire w_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  localparam logic [11:0] STS_ADDR = OTR_IDX_CAL_STS << OTR_IDX_SHIFT;
  // status word is always readable; holes answer slverr anyway
  wire r_hs = s_axi_arvalid && s_axi_arready;
  wire r_trim = r_hs && (s_axi_araddr != STS_ADDR);
  wire bg_both = background_cal_enable && background_offset_cal_enable;
  wire fg_gate = foreground_offset_cal_enable &&
                 !background_offset_cal_enable && !foreground_cal_done_flag;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (
    w_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  a_read_answer: assert property (r_hs |=> s_axi_rvalid)
    else $error("read data not one cycle after handshake");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped before taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_fg_write_block: assert property (
    w_hs && foreground_cal_running |=> ##1 s_axi_bresp == OTR_RESP_SLVERR)
    else $error("write during fg cal");
  a_bg_write_block: assert property (w_hs && bg_both |=>
    ##1 s_axi_bresp == OTR_RESP_SLVERR) else $error("write during bg cal");
  a_fg_read_gate: assert property (r_trim && fg_gate |=>
    s_axi_rresp == OTR_RESP_SLVERR) else $error("read before foreground_cal_done_flag");
  a_bg_read_gate: assert property (
    r_trim && bg_both && !calibration_stopped_flag
    |=> s_axi_rresp == OTR_RESP_SLVERR) else $error("read while bg runs");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
endmodule : otr_trim_bank_chk
bind otr_trim_bank otr_trim_bank_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .foreground_cal_running, .background_cal_enable,
  .background_offset_cal_enable, .foreground_offset_cal_enable,
  .foreground_cal_done_flag, .calibration_stopped_flag);

// file: dv/otr_trim_bank_tb_top.sv
// testbench: register access, calibration gating and trim datapath
`timescale 1ns/10ps
module otr_trim_bank_tb_top;
  import otr_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sel = 2'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [5:0]  cal = 6'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [11:0] smp1 = 12'h0, smp2 = 12'h0;
  logic [12:0] cor1, cor2;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h1f82;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          err_count = 0, total_checks = 0;
  logic [15:0] m[4] = '{{OTR_RSV_RESET, OTR_FACTORY_C1_INA},
    {OTR_RSV_RESET, OTR_FACTORY_C1_INB}, {OTR_RSV_RESET, OTR_FACTORY_C2_INA},
    {OTR_RSV_RESET, OTR_FACTORY_C2_INB}};
  // last three entries: status, an unmapped and a misaligned word
  localparam logic [11:0] ADR[7] = '{OTR_IDX_C1_INA << 2, OTR_IDX_C1_INB << 2,
    OTR_IDX_C2_INA << 2, OTR_IDX_C2_INB << 2, OTR_IDX_CAL_STS << 2, 12'h100,
    12'h239};
  wire wa = !cal[0] && !(cal[1] && cal[2]);
  wire ra = !(cal[3] && !cal[2] && !cal[4]) && !(cal[1] && cal[2] && !cal[5]);
  otr_trim_bank u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .foreground_cal_running(cal[0]), .background_cal_enable(cal[1]),
    .background_offset_cal_enable(cal[2]),
    .foreground_offset_cal_enable(cal[3]),
    .foreground_cal_done_flag(cal[4]), .calibration_stopped_flag(cal[5]),
    .core1_on_input_b(sel[0]), .core2_on_input_b(sel[1]), .core1_sample(smp1),
    .core2_sample(smp2), .core1_corrected(cor1), .core2_corrected(cor2));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // guards read old values so no signal is assigned twice in one step
  task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
    bq.push_back((i < 4 && wa) ? OTR_RESP_OKAY
                               : OTR_RESP_SLVERR);
    if (i < 4 && wa && s[0]) m[i][7:0] = d[7:0];
    if (i < 4 && wa && s[1]) m[i][15:8] = d[15:8];
    s_axi_awaddr <= ADR[i];
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_bready);
  endtask : wr
  task automatic rd(input int i);
    if (i < 4) rq.push_back({ra ? OTR_RESP_OKAY : OTR_RESP_SLVERR, 16'h0, m[i]});
    else if (i == 4) rq.push_back({OTR_RESP_OKAY, 24'h0, ra, wa, cal});
    else rq.push_back({OTR_RESP_SLVERR, 32'h0});
    s_axi_araddr <= ADR[i];
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_rready);
  endtask : rd
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata},
          rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    close_out();
  end
  initial begin
    logic [31:0] r, w;
    logic [12:0] e1, e2;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(i);
    repeat (80) begin
      r = xs();
      w = xs();
      cal <= {r[5:1], r[0] & r[6]};
      sel <= r[8:7];
      smp1 <= r[20:9];
      smp2 <= w[31:20];
      @(posedge aclk);
      wr(r[31:16] % 7, w[15:0], w[19:16]);
      rd(r[31:16] % 7);
      rd(r[15:9] % 7);
      e1 = {1'b0, smp1} + {1'b0, m[{1'b0, sel[0]}][11:0]};
      e2 = {1'b0, smp2} + {1'b0, m[{1'b1, sel[1]}][11:0]};
      chk({21'h0, cor1}, {21'h0, e1});
      chk({21'h0, cor2}, {21'h0, e2});
    end
    close_out();
  end
endmodule : otr_trim_bank_tb_top
